/* pkg/cqc_pkg.sv */
// Package: register map, field layouts and types of the completion queue control block
package cqc_pkg;

  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] CQC_UPPER_ADDR_OFF = 8'hb4;
  localparam logic [7:0] CQC_TX_CTRL_OFF = 8'hb8;
  localparam logic [7:0] CQC_RX1_CTRL_OFF = 8'hbc;
  localparam logic [7:0] CQC_READ_POS_OFF = 8'hc4;
  localparam logic [7:0] CQC_TX_WPOS_OFF = 8'hd0;
  localparam logic [7:0] CQC_RX1_WPOS_OFF = 8'hd4;
  localparam logic [7:0] CQC_IRQ_STATUS_OFF = 8'hd8;
  localparam logic [7:0] CQC_IRQ_MASK_OFF = 8'hdc;

  // ------------------------------------------------------------
  // Field positions and sizes
  // ------------------------------------------------------------
  localparam int CQC_BASE_LSB = 8;
  localparam int CQC_WIDE_BIT = 7;
  localparam int CQC_PWE_BIT = 6;
  localparam int CQC_SIZE_BIT = 5;
  localparam int CQC_SINGLE_BIT = 4;
  localparam int CQC_FMT_LSB = 4;
  localparam int CQC_TX_MODE_BIT = 31;
  localparam int CQC_RX1_MODE_BIT = 15;
  localparam int CQC_TX_RPOS_LSB = 16;
  localparam int CQC_RX1_RPOS_LSB = 0;
  localparam int CQC_IDX_W = 10;
  localparam logic [10:0] CQC_ENTRIES = 11'h0400;
  localparam logic [31:0] CQC_READ_POS_MASK = 32'h83ff_83ff;
  localparam logic [31:0] CQC_RESET_WORD = 32'h0000_0000;
  localparam int CQC_IRQ_W = 2;

  // Receive entry formats
  typedef enum logic [1:0] {
    CQC_FMT_ONE_WORD = 2'b00,
    CQC_FMT_TWO_VLAN = 2'b01,
    CQC_FMT_TWO_CSUM = 2'b10,
    CQC_FMT_FOUR_WORD = 2'b11
  } cqc_fmt_t;

  // Avalon bus state
  typedef enum logic [0:0] {
    CQC_BUS_IDLE = 1'b0,
    CQC_BUS_DONE = 1'b1
  } cqc_bus_st_t;

  // Completion request from the producing engines
  typedef struct packed {
    logic valid;
    logic is_rx;
    logic [63:0] data;
  } cqc_req_t;

  // Host memory write toward the bus master
  typedef struct packed {
    logic valid;
    logic wide;
    logic [63:0] addr;
    logic [63:0] data;
    logic [3:0] words;
  } cqc_wr_t;

endpackage

/* hw/cqc_queue.sv */
// One completion ring: fill level, threshold compare and entry address
`timescale 1ns/10ps
module cqc_queue
  import cqc_pkg::*;
#(
  parameter int IDX_W = CQC_IDX_W
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Settings
  input wire logic [IDX_W-1:0] write_position_i,
  input wire logic [IDX_W-1:0] read_position_i,
  input wire logic [3:0] fill_level_limit_i,
  input wire logic limit_compare_select_i,
  input wire logic [23:0] queue_base_i,
  input wire logic wide_addressing_i,
  input wire logic [31:0] shared_upper_address_i,
  input wire logic [4:0] step_bytes_i,
  // Status
  output logic empty_o,
  output logic full_o,
  output logic limit_hit_o,
  output logic [63:0] entry_addr_o
);

  typedef struct packed {
    logic limit_hit;
  } cqc_q_state_t;

  cqc_q_state_t state_reg;
  cqc_q_state_t state_next;
  logic [IDX_W-1:0] valid_cnt;
  logic [IDX_W:0] empty_cnt;
  logic [IDX_W:0] limit;
  logic [31:0] offset;

  // Ring occupancy
  assign empty_o = (write_position_i == read_position_i);
  assign full_o = (IDX_W'(write_position_i + 1'b1) == read_position_i);
  assign valid_cnt = IDX_W'(write_position_i - read_position_i);
  assign empty_cnt = (IDX_W + 1)'(CQC_ENTRIES) - {1'b0, valid_cnt};
  assign limit = (IDX_W + 1)'({fill_level_limit_i, 2'b00});

  // Host address of the next entry
  assign offset = 32'(write_position_i) * 32'(step_bytes_i);
  assign entry_addr_o = {wide_addressing_i ? shared_upper_address_i : 32'h0000_0000,
                         32'({queue_base_i, 8'h00}) + offset};
  assign limit_hit_o = state_reg.limit_hit;

  // Threshold compare in the selected mode
  always_comb
  begin
    state_next = state_reg;
    if (limit_compare_select_i)
      state_next.limit_hit = ({1'b0, valid_cnt} >= limit);
    else
      state_next.limit_hit = (empty_cnt <= limit);
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

endmodule

/* hw/cqc_top.sv */
// Completion queue control: registers, queue routing and descriptor writes
//
// Overview of operation
// - Each queue has 1024 slots and holds up to 1023 entries
// - Shared upper register gives address bits 63:32
// - Wide bit selects 64-bit master addressing
// - Write position writes need enable bit 6
// - Tx enable clear stops tx entries
// - Tx size bit picks 8 or 4 bytes
// - Single queue mode routes all to tx
// - Single mode limits rx entries to 8 bytes
// - Tx threshold is four times bits 3:0
// - Tx status by empty or valid compare
// - Rx1 format field selects entry words
// - Rx1 threshold and compare as tx
// - Read position bit 31 selects tx mode
// - Equal positions empty, plus one full
// - Positions step by one, entry address by entry size
`timescale 1ns/10ps
module cqc_top
  import cqc_pkg::*;
#(
  parameter int IDX_W = CQC_IDX_W
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Completion requests from the engines
  input wire cqc_req_t comp_req_i,
  output logic comp_ready_o,
  // Descriptor writes to the host bus master
  output cqc_wr_t host_wr_o,
  input wire logic host_ready_i,
  // Interrupt
  output logic irq_o
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    cqc_bus_st_t bus_st;
    logic [31:0] rdata;
    logic [31:0] shared_upper_address;
    logic [31:0] tx_ctrl;
    logic [31:0] rx1_ctrl;
    logic [31:0] read_pos;
    logic [IDX_W-1:0] tx_write_position;
    logic [IDX_W-1:0] rx1_write_position;
    logic [CQC_IRQ_W-1:0] irq_status;
    logic [CQC_IRQ_W-1:0] irq_mask;
    logic [CQC_IRQ_W-1:0] hit_d;
    cqc_wr_t wr;
  } cqc_state_t;

  cqc_state_t state_reg;
  cqc_state_t state_next;

  // ------------------------------------------------------------
  // Decoded fields
  // ------------------------------------------------------------
  logic tx_producer_write_enable;
  logic rx1_producer_write_enable;
  logic tx_descriptor_size_select;
  logic single_queue_mode;
  logic tx_queue_wide_addressing;
  logic rx1_wide_addressing;
  cqc_fmt_t rx1_entry_format;
  logic [4:0] tx_step;
  logic [4:0] rx1_step;
  logic [3:0] rx1_words;
  logic [3:0] req_words;
  logic tx_empty;
  logic tx_full;
  logic tx_hit;
  logic rx1_empty;
  logic rx1_full;
  logic rx1_hit;
  logic [63:0] tx_addr;
  logic [63:0] rx1_addr;
  logic to_rx1;
  logic target_full;
  logic target_on;
  logic accept;
  logic bus_go;
  logic bus_wr;
  logic [31:0] wmask;

  assign tx_queue_wide_addressing = state_reg.tx_ctrl[CQC_WIDE_BIT];
  assign tx_producer_write_enable = state_reg.tx_ctrl[CQC_PWE_BIT];
  assign tx_descriptor_size_select = state_reg.tx_ctrl[CQC_SIZE_BIT];
  assign single_queue_mode = state_reg.tx_ctrl[CQC_SINGLE_BIT];
  assign rx1_wide_addressing = state_reg.rx1_ctrl[CQC_WIDE_BIT];
  assign rx1_producer_write_enable = state_reg.rx1_ctrl[CQC_PWE_BIT];
  assign rx1_entry_format = cqc_fmt_t'(state_reg.rx1_ctrl[CQC_FMT_LSB +: 2]);

  // Entry sizes in bytes and 32-bit words
  assign tx_step = tx_descriptor_size_select ? 5'h08 : 5'h04;
  always_comb
  begin
    case (rx1_entry_format)
      CQC_FMT_ONE_WORD: rx1_words = 4'h1;
      CQC_FMT_TWO_VLAN: rx1_words = 4'h2;
      CQC_FMT_TWO_CSUM: rx1_words = 4'h2;
      CQC_FMT_FOUR_WORD: rx1_words = 4'h4;
      default: rx1_words = 4'h1;
    endcase
  end
  assign rx1_step = 5'({rx1_words, 2'b00});

  // ------------------------------------------------------------
  // Queue instances
  // ------------------------------------------------------------
  cqc_queue #(.IDX_W(IDX_W)) u_tx_queue (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .write_position_i(state_reg.tx_write_position),
    .read_position_i(state_reg.read_pos[CQC_TX_RPOS_LSB +: IDX_W]),
    .fill_level_limit_i(state_reg.tx_ctrl[3:0]),
    .limit_compare_select_i(state_reg.read_pos[CQC_TX_MODE_BIT]),
    .queue_base_i(state_reg.tx_ctrl[31:CQC_BASE_LSB]),
    .wide_addressing_i(tx_queue_wide_addressing),
    .shared_upper_address_i(state_reg.shared_upper_address),
    .step_bytes_i(tx_step),
    .empty_o(tx_empty),
    .full_o(tx_full),
    .limit_hit_o(tx_hit),
    .entry_addr_o(tx_addr)
  );

  cqc_queue #(.IDX_W(IDX_W)) u_rx1_queue (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .write_position_i(state_reg.rx1_write_position),
    .read_position_i(state_reg.read_pos[CQC_RX1_RPOS_LSB +: IDX_W]),
    .fill_level_limit_i(state_reg.rx1_ctrl[3:0]),
    .limit_compare_select_i(state_reg.read_pos[CQC_RX1_MODE_BIT]),
    .queue_base_i(state_reg.rx1_ctrl[31:CQC_BASE_LSB]),
    .wide_addressing_i(rx1_wide_addressing),
    .shared_upper_address_i(state_reg.shared_upper_address),
    .step_bytes_i(rx1_step),
    .empty_o(rx1_empty),
    .full_o(rx1_full),
    .limit_hit_o(rx1_hit),
    .entry_addr_o(rx1_addr)
  );

  // ------------------------------------------------------------
  // Completion routing
  // ------------------------------------------------------------
  // Rx completions go to rx1 unless single queue mode overrides it
  assign to_rx1 = comp_req_i.is_rx && !single_queue_mode;
  assign target_full = to_rx1 ? rx1_full : tx_full;
  assign target_on = to_rx1 ? 1'b1 : tx_producer_write_enable;
  assign comp_ready_o = !state_reg.wr.valid && target_on && !target_full;
  assign accept = comp_req_i.valid && comp_ready_o;
  always_comb
  begin
    if (to_rx1)
      req_words = rx1_words;
    else if (comp_req_i.is_rx)
      req_words = 4'h2;
    else
      req_words = tx_descriptor_size_select ? 4'h2 : 4'h1;
  end

  // ------------------------------------------------------------
  // Bus handshake and byte lanes
  // ------------------------------------------------------------
  assign bus_go = (avs_read_i || avs_write_i) && (state_reg.bus_st == CQC_BUS_IDLE);
  // Writes land only at the edge where waitrequest is seen low
  assign bus_wr = avs_write_i && (state_reg.bus_st == CQC_BUS_DONE);
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (state_reg.bus_st == CQC_BUS_IDLE);
  assign avs_readdata_o = state_reg.rdata;
  assign host_wr_o = state_reg.wr;
  assign irq_o = |(state_reg.irq_status & state_reg.irq_mask);

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_lane
      assign wmask[8*g +: 8] = {8{avs_byteenable_i[g]}};
    end
  endgenerate

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.hit_d = {rx1_hit, tx_hit};
    // Bus answers one cycle after the request appears
    case (state_reg.bus_st)
      CQC_BUS_IDLE: if (bus_go) state_next.bus_st = CQC_BUS_DONE;
      CQC_BUS_DONE: state_next.bus_st = CQC_BUS_IDLE;
      default: state_next.bus_st = CQC_BUS_IDLE;
    endcase
    // Host write leaves when the master takes it
    if (state_reg.wr.valid && host_ready_i)
      state_next.wr.valid = 1'b0;
    // New completion descriptor
    if (accept)
    begin
      state_next.wr.valid = 1'b1;
      state_next.wr.data = comp_req_i.data;
      state_next.wr.words = req_words;
      if (to_rx1)
      begin
        state_next.wr.addr = rx1_addr;
        state_next.wr.wide = rx1_wide_addressing;
        state_next.rx1_write_position = IDX_W'(state_reg.rx1_write_position + 1'b1);
      end
      else
      begin
        state_next.wr.addr = tx_addr;
        state_next.wr.wide = tx_queue_wide_addressing;
        state_next.tx_write_position = IDX_W'(state_reg.tx_write_position + 1'b1);
      end
    end
    // Register access
    if (bus_go && avs_read_i)
    begin
      case (avs_address_i)
        CQC_UPPER_ADDR_OFF: state_next.rdata = state_reg.shared_upper_address;
        CQC_TX_CTRL_OFF: state_next.rdata = state_reg.tx_ctrl;
        CQC_RX1_CTRL_OFF: state_next.rdata = state_reg.rx1_ctrl;
        CQC_READ_POS_OFF: state_next.rdata = state_reg.read_pos;
        CQC_TX_WPOS_OFF: state_next.rdata = 32'(state_reg.tx_write_position);
        CQC_RX1_WPOS_OFF: state_next.rdata = 32'(state_reg.rx1_write_position);
        CQC_IRQ_STATUS_OFF: state_next.rdata = 32'(state_reg.irq_status);
        CQC_IRQ_MASK_OFF: state_next.rdata = 32'(state_reg.irq_mask);
        default: state_next.rdata = CQC_RESET_WORD;
      endcase
    end
    if (bus_wr)
    begin
      case (avs_address_i)
        CQC_UPPER_ADDR_OFF: state_next.shared_upper_address =
          (state_reg.shared_upper_address & ~wmask) | (avs_writedata_i & wmask);
        CQC_TX_CTRL_OFF: state_next.tx_ctrl =
          (state_reg.tx_ctrl & ~wmask) | (avs_writedata_i & wmask);
        CQC_RX1_CTRL_OFF: state_next.rx1_ctrl =
          (state_reg.rx1_ctrl & ~wmask) | (avs_writedata_i & wmask);
        CQC_READ_POS_OFF: state_next.read_pos = ((state_reg.read_pos & ~wmask) |
          (avs_writedata_i & wmask)) & CQC_READ_POS_MASK;
        CQC_TX_WPOS_OFF:
          if (tx_producer_write_enable && !accept)
            state_next.tx_write_position = avs_writedata_i[IDX_W-1:0];
        CQC_RX1_WPOS_OFF:
          if (rx1_producer_write_enable && !accept)
            state_next.rx1_write_position = avs_writedata_i[IDX_W-1:0];
        CQC_IRQ_MASK_OFF: state_next.irq_mask = avs_writedata_i[CQC_IRQ_W-1:0];
        default: ;
      endcase
    end
    // Sticky status: clear by writing one, a new rising hit wins
    if (bus_wr && avs_address_i == CQC_IRQ_STATUS_OFF)
      state_next.irq_status = state_reg.irq_status & ~avs_writedata_i[CQC_IRQ_W-1:0];
    state_next.irq_status = state_next.irq_status |
      ({rx1_hit, tx_hit} & ~state_reg.hit_d);
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

endmodule

/* sim/cqc_monitor.sv */
// Port checker of the completion queue control block
`timescale 1ns/10ps
module cqc_monitor
  import cqc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Bus, requests, writes, interrupt
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  input wire cqc_req_t comp_req_i,
  input wire logic comp_ready_o,
  input wire cqc_wr_t host_wr_o,
  input wire logic host_ready_i,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [31:0] tx_reg;
  logic [31:0] rx_reg;
  logic [31:0] up_reg;
  logic take, acc, to_tx, exp_wide;
  logic [3:0] exp_words;
  // Request decode and expected entry shape
  assign take = avs_write_i && !avs_waitrequest_o && (avs_byteenable_i == 4'hf);
  assign acc = comp_req_i.valid && comp_ready_o;
  assign to_tx = !comp_req_i.is_rx || tx_reg[CQC_SINGLE_BIT];
  assign exp_wide = to_tx ? tx_reg[CQC_WIDE_BIT] : rx_reg[CQC_WIDE_BIT];
  always_comb
  begin
    exp_words = (rx_reg[5:4] == 2'b00) ? 4'h1 : 4'h2;
    if (rx_reg[5:4] == 2'b11)
      exp_words = 4'h4;
    if (to_tx)
      exp_words = (comp_req_i.is_rx || tx_reg[CQC_SIZE_BIT]) ? 4'h2 : 4'h1;
  end
  // Shadow of the software control words
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_reg <= 32'h0000_0000;
      rx_reg <= 32'h0000_0000;
      up_reg <= 32'h0000_0000;
    end
    else if (take)
    begin
      if (avs_address_i == CQC_TX_CTRL_OFF)
        tx_reg <= avs_writedata_i;
      if (avs_address_i == CQC_RX1_CTRL_OFF)
        rx_reg <= avs_writedata_i;
      if (avs_address_i == CQC_UPPER_ADDR_OFF)
        up_reg <= avs_writedata_i;
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_wait_first: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("waitrequest low in first cycle");
  a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("waitrequest longer than one cycle");
  a_host_hold: assert property (host_wr_o.valid && !host_ready_i |=> host_wr_o.valid
    && $stable(host_wr_o)) else $error("host write changed while stalled");
  a_accept_out: assert property (acc |=> host_wr_o.valid) else $error("no host write");
  a_tx_closed: assert property (comp_req_i.valid && to_tx && !tx_reg[CQC_PWE_BIT]
    |-> !comp_ready_o) else $error("entry taken into closed queue");
  a_entry_words: assert property (acc |=> host_wr_o.words == $past(exp_words))
    else $error("wrong entry size");
  a_wide_mode: assert property (acc |=> host_wr_o.wide == $past(exp_wide))
    else $error("wrong addressing mode");
  a_upper_addr: assert property (acc |=> host_wr_o.addr[63:32] ==
    ($past(exp_wide) ? $past(up_reg) : 32'h0000_0000)) else $error("wrong upper address");
  a_mask_off: assert property (take && avs_address_i == CQC_IRQ_MASK_OFF &&
    avs_writedata_i == 32'h0000_0000 |=> !irq_o) else $error("masked interrupt high");
  c_tx_entry: cover property (acc && !comp_req_i.is_rx);
  c_rx_entry: cover property (acc && comp_req_i.is_rx);
  c_irq_rise: cover property ($rose(irq_o));
endmodule

bind cqc_top cqc_monitor mon_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_waitrequest_o(avs_waitrequest_o), .comp_req_i(comp_req_i),
  .comp_ready_o(comp_ready_o), .host_wr_o(host_wr_o), .host_ready_i(host_ready_i),
  .irq_o(irq_o));

/* sim/cqc_host_model.sv */
// Host memory model: takes descriptor writes promptly or after stalls
`timescale 1ns/10ps
module cqc_host_model
  import cqc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Write channel
  input wire cqc_wr_t host_wr_i,
  input wire logic slow_i,
  output logic host_ready_o,
  // Last write taken and write count
  output cqc_wr_t last_o,
  output logic [7:0] cnt_o
);
  logic [1:0] wait_reg;
  // Slow mode stalls each write for three cycles
  assign host_ready_o = host_wr_i.valid && (!slow_i || wait_reg == 2'h3);
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      last_o <= '0;
      cnt_o <= 8'h00;
      wait_reg <= 2'h0;
    end
    else if (host_ready_o)
    begin
      last_o <= host_wr_i;
      cnt_o <= cnt_o + 8'h01;
      wait_reg <= 2'h0;
    end
    else if (host_wr_i.valid)
      wait_reg <= wait_reg + 2'h1;
  end
endmodule

/* sim/tb_top.sv */
// Register and completion path testbench of the completion queue control block
`timescale 1ns/10ps
module tb_top
  import cqc_pkg::*;
;
  localparam logic [31:0] UP = 32'h1234_5678;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic rd, wr, wreq, ready, irq, hrdy, slow;
  logic [7:0] addr, cnt;
  logic [31:0] wdata, rdata, q;
  logic [3:0] w [4] = '{4'h1, 4'h2, 4'h2, 4'h4};
  cqc_req_t req;
  cqc_wr_t hw, last;
  int errors = 0;
  int checked = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  cqc_top #(.IDX_W(CQC_IDX_W)) dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .comp_req_i(req), .comp_ready_o(ready), .host_wr_o(hw), .host_ready_i(hrdy),
    .irq_o(irq));
  cqc_host_model mdl_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .host_wr_i(hw),
    .slow_i(slow), .host_ready_o(hrdy), .last_o(last), .cnt_o(cnt));
  // Compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic wt, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    addr <= a;
    wr <= wt;
    rd <= !wt;
    wdata <= d;
    do
    begin
      @(negedge clk_sys_i);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    chk(64'(n < 50), 64'h1);
    // Waitrequest low is sampled at this edge; read data taken here too
    @(posedge clk_sys_i);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk_sys_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  // One completion, checked at the host model
  task automatic send(input logic rx, input logic [63:0] ea, input logic [3:0] ew);
    int n;
    logic [7:0] c0;
    n = 0;
    c0 = cnt;
    @(posedge clk_sys_i);
    req <= '{1'b1, rx, ~ea};
    do
    begin
      @(negedge clk_sys_i);
      n++;
    end
    while (ready !== 1'b1 && n < 50);
    @(posedge clk_sys_i);
    req.valid <= 1'b0;
    do
    begin
      @(negedge clk_sys_i);
      n++;
    end
    while (cnt == c0 && n < 90);
    chk(64'(n < 90), 64'h1);
    chk(last.addr, ea);
    chk(last.data, ~ea);
    chk(64'(last.words), 64'(ew));
    chk(64'(last.wide), 64'(|ea[63:32]));
  endtask
  task automatic test_done;
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    slow = 1'b0;
    req = '0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rdc(CQC_UPPER_ADDR_OFF, 32'h0000_0000);
    rdc(8'he0, 32'h0000_0000);
    bus(1'b1, CQC_TX_WPOS_OFF, 32'h0000_0005);
    rdc(CQC_TX_WPOS_OFF, 32'h0000_0000);
    bus(1'b1, CQC_UPPER_ADDR_OFF, UP);
    rdc(CQC_UPPER_ADDR_OFF, UP);
    bus(1'b1, CQC_TX_CTRL_OFF, 32'h0010_00c0);
    bus(1'b1, CQC_TX_WPOS_OFF, 32'h0000_0003);
    rdc(CQC_TX_WPOS_OFF, 32'h0000_0003);
    bus(1'b1, CQC_TX_WPOS_OFF, 32'h0000_0000);
    send(1'b0, {UP, 32'h0010_0000}, 4'h1);
    bus(1'b1, CQC_TX_CTRL_OFF, 32'h0010_00e0);
    slow <= 1'b1;
    send(1'b0, {UP, 32'h0010_0008}, 4'h2);
    rdc(CQC_TX_WPOS_OFF, 32'h0000_0002);
    for (int f = 0; f < 4; f++)
    begin
      bus(1'b1, CQC_RX1_CTRL_OFF, 32'h0020_0040 | 32'(f << 4));
      send(1'b1, {32'h0, 32'h0020_0000 + 32'(f * 4 * w[f])}, w[f]);
    end
    rdc(CQC_RX1_WPOS_OFF, 32'h0000_0004);
    bus(1'b1, CQC_TX_CTRL_OFF, 32'h0010_00f0);
    send(1'b1, {UP, 32'h0010_0010}, 4'h2);
    rdc(CQC_TX_WPOS_OFF, 32'h0000_0003);
    rdc(CQC_RX1_WPOS_OFF, 32'h0000_0004);
    bus(1'b1, CQC_TX_CTRL_OFF, 32'h0010_0020);
    @(posedge clk_sys_i);
    req <= '{1'b1, 1'b0, 64'h0};
    repeat (6) @(negedge clk_sys_i);
    chk(64'(ready), 64'h0);
    chk(64'(cnt), 64'h7);
    @(posedge clk_sys_i);
    req.valid <= 1'b0;
    bus(1'b1, CQC_TX_CTRL_OFF, 32'h0010_00e1);
    bus(1'b1, CQC_IRQ_MASK_OFF, 32'h0000_0001);
    bus(1'b1, CQC_READ_POS_OFF, 32'h8003_0000);
    rdc(CQC_READ_POS_OFF, 32'h8003_0000);
    for (int i = 0; i < 4; i++)
    begin
      chk(64'(irq), 64'h0);
      send(1'b0, {UP, 32'h0010_0000 + 32'((3 + i) * 8)}, 4'h2);
    end
    rdc(CQC_IRQ_STATUS_OFF, 32'h0000_0001);
    chk(64'(irq), 64'h1);
    bus(1'b1, CQC_IRQ_MASK_OFF, 32'h0000_0000);
    chk(64'(irq), 64'h0);
    bus(1'b1, CQC_IRQ_MASK_OFF, 32'h0000_0001);
    chk(64'(irq), 64'h1);
    bus(1'b1, CQC_IRQ_STATUS_OFF, 32'h0000_0001);
    chk(64'(irq), 64'h0);
    rdc(CQC_IRQ_STATUS_OFF, 32'h0000_0000);
    // Write position one behind the read position: ring full
    bus(1'b1, CQC_TX_WPOS_OFF, 32'h0000_0002);
    rdc(CQC_TX_WPOS_OFF, 32'h0000_0002);
    @(posedge clk_sys_i);
    req <= '{1'b1, 1'b0, 64'h0};
    repeat (2) @(negedge clk_sys_i);
    chk(64'(ready), 64'h0);
    @(posedge clk_sys_i);
    req.valid <= 1'b0;
    test_done;
  end
  // Watchdog
  initial
  begin
    #200000;
    errors++;
    test_done;
  end
endmodule
